// ===== common/acrfcm_pkg.sv
// Purpose: shared constants for the converter result-format and charge-unit
//          control block
// Assumes: 16-bit register port, word-indexed register offsets
// Notes:   result buffer holds the raw signed code; formatting is on read
package acrfcm_pkg;
    // register port shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register offsets (word index)
    localparam logic [ADDR_W-1:0] REG_CTRL1  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CLKDIV = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CHSEL  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_ENLO   = 4'h3;
    localparam logic [ADDR_W-1:0] REG_ENHI   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_RESULT = 4'h5;

    // converter_control_register_1 fields
    localparam int CTRL_ON_BIT   = 15;
    localparam int CTRL_RES_BIT  = 10;
    localparam int CTRL_OUTPUT_FORMAT_SELECT_LSB = 8;
    localparam int CTRL_BUSY_BIT = 2;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_DONE_BIT = 0;

    // channel and field sizes
    localparam int NUM_CHAN = 18;
    localparam int CHAN_W   = 5;
    localparam int ENLO_W   = 16;
    localparam int ENHI_W   = 2;
    localparam int DIV_W    = 8;
    localparam int RAW_W    = 13;
    localparam int IN_W     = 16;

    // saturation limits of the two resolutions
    localparam logic signed [IN_W-1:0] CODE12_MAX = 16'sh0FFF;
    localparam logic signed [IN_W-1:0] CODE12_MIN = -16'sh1000;
    localparam logic signed [IN_W-1:0] CODE10_MAX = 16'sh03FF;
    localparam logic signed [IN_W-1:0] CODE10_MIN = -16'sh0400;
    localparam int RES10_SHIFT = 2;

    // conversion sequence lengths in conversion clock periods
    localparam int SAMPLE_TADS = 1;
    localparam int CONV_TADS   = 14;

    // justification of the fractional formats
    localparam int FRAC12_PAD  = 4;
    localparam int SFRAC12_PAD = 3;
    localparam int FRAC10_PAD  = 6;
    localparam int SFRAC10_PAD = 5;

    // output format codes held in the format field
    typedef enum logic [1:0] {
        OUTPUT_FORMAT_SELECT_INT   = 2'h0,
        OUTPUT_FORMAT_SELECT_SINT  = 2'h1,
        OUTPUT_FORMAT_SELECT_FRAC  = 2'h2,
        OUTPUT_FORMAT_SELECT_SFRAC = 2'h3
    } acrfcm_output_format_select_e;
endpackage

// ===== rtl/acrfcm_clkdiv.sv
// Purpose: conversion clock from the instruction cycle by a divisor
// Assumes: one instruction cycle per system clock
// Notes:   period is divisor plus one cycles; restarts when run drops
`timescale 1ns/100ps
module acrfcm_clkdiv
    import acrfcm_pkg::*;
(
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    input  wire logic             i_run,
    input  wire logic [DIV_W-1:0] i_divisor,
    output logic                  o_tick,
    output logic                  o_tad_clk
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
        logic             tad_clk;
    } acrfcm_div_s;

    acrfcm_div_s div_reg;
    acrfcm_div_s div_next;

    // count divisor+1 cycles per conversion clock period
    always_comb begin
        div_next = div_reg;
        div_next.tick = 1'b0;
        if (!i_run) begin
            div_next.cnt = '0;
            div_next.tad_clk = 1'b0;
        end else if (div_reg.cnt >= i_divisor) begin
            div_next.cnt = '0;
            div_next.tick = 1'b1;
            div_next.tad_clk = 1'b1;
        end else begin
            div_next.cnt = div_reg.cnt + 1'b1;
            // low for the later half of the period
            if (div_reg.cnt >= (i_divisor >> 1)) begin
                div_next.tad_clk = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign o_tick = div_reg.tick;
    assign o_tad_clk = div_reg.tad_clk;
endmodule

// ===== rtl/acrfcm_format.sv
// Purpose: justify and sign-extend the stored code for a bus read
// Assumes: raw code is two's complement, sign-extended to 13 bits
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
module acrfcm_format
    import acrfcm_pkg::*;
(
    input  wire logic [RAW_W-1:0]  i_raw,
    input  wire logic              i_res12,
    input  wire logic [1:0]        i_output_format_select,
    output logic      [DATA_W-1:0] o_word
);
    logic neg;
    logic [DATA_W-1:0] sext;

    // sign sits in bit 12 or bit 10 and fills upward
    assign neg = i_res12 ? i_raw[RAW_W-1] : i_raw[10];
    assign sext = {{(DATA_W-RAW_W){i_raw[RAW_W-1]}}, i_raw};

    // unsigned forms drop negative codes to zero
    always_comb begin
        o_word = '0;
        unique case (acrfcm_output_format_select_e'(i_output_format_select))
            OUTPUT_FORMAT_SELECT_INT: begin
                if (!neg) begin
                    o_word = i_res12 ? {4'h0, i_raw[11:0]}
                                     : {6'h00, i_raw[9:0]};
                end
            end
            OUTPUT_FORMAT_SELECT_SINT: begin
                o_word = sext;
            end
            OUTPUT_FORMAT_SELECT_FRAC: begin
                if (!neg) begin
                    o_word = i_res12
                        ? {i_raw[11:0], {FRAC12_PAD{1'b0}}}
                        : {i_raw[9:0], {FRAC10_PAD{1'b0}}};
                end
            end
            OUTPUT_FORMAT_SELECT_SFRAC: begin
                o_word = i_res12
                    ? {i_raw[12:0], {SFRAC12_PAD{1'b0}}}
                    : {i_raw[10:0], {SFRAC10_PAD{1'b0}}};
            end
        endcase
    end
endmodule

// ===== rtl/acrfcm_top.sv
// Purpose: converter control with result formatting and charge-unit
//          channel connection
// Assumes: differential input arrives as a signed count of 1/4096 span
//          steps from a front end on the same clock
// Notes:   registers are word-indexed on a plain strobe port
`timescale 1ns/100ps
module acrfcm_top
    import acrfcm_pkg::*;
#(
    parameter logic [NUM_CHAN-1:0] CHAN_IMPL = 18'h3FFFF,
    parameter int                  CONV_LEN  = CONV_TADS,
    parameter int                  SAMP_LEN  = SAMPLE_TADS
)
(
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_n,
    input  wire logic [ADDR_W-1:0]     i_addr,
    input  wire logic [DATA_W-1:0]     i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic signed [IN_W-1:0] i_diff_input,
    output logic      [DATA_W-1:0]     o_rdata,
    output logic                       o_conv_clock,
    output logic                       o_sampling,
    output logic                       o_converting,
    output logic                       o_charge_unit_connect,
    output logic      [CHAN_W-1:0]     o_charge_unit_channel,
    output logic                       o_done
);
    localparam int CNT_W = 5;

    // refuse sequence lengths the phase counter cannot hold
    if (CONV_LEN < 1 || CONV_LEN >= (1 << CNT_W)) begin : g_bad_conv
        $error("conversion length out of range");
    end
    if (SAMP_LEN < 1 || SAMP_LEN >= (1 << CNT_W)) begin : g_bad_samp
        $error("sample length out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } acrfcm_state_e;

    typedef struct packed {
        acrfcm_state_e     st;
        logic              on;
        logic              res12;
        logic [1:0]        output_format_select;
        logic [DIV_W-1:0]  div;
        logic [CHAN_W-1:0] chsel;
        logic [ENLO_W-1:0] en_lo;
        logic [ENHI_W-1:0] en_hi;
        logic [RAW_W-1:0]  buffer;
        logic              done;
        logic [CNT_W-1:0]  phase;
        logic [CHAN_W-1:0] conv_ch;
        logic              connect;
        logic [DATA_W-1:0] rdata;
        logic              sampling;
        logic              converting;
    } acrfcm_top_s;

    acrfcm_top_s top_reg;
    acrfcm_top_s top_next;

    logic [1:0]          rst_sync_reg;
    logic                rst_n;
    logic                tad_tick;
    logic                tad_clk;
    logic                div_run;
    logic [DATA_W-1:0]   fmt_word;
    logic [NUM_CHAN-1:0] en_all;
    logic [NUM_CHAN-1:0] en_seen;
    logic [RAW_W-1:0]    quant;

    // release reset through two flops; assertion stays asynchronous
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // divider follows the next state so that it counts from the start
    // edge; a registered run would stretch the first period by a cycle
    assign div_run = (top_next.st != ST_IDLE);

    acrfcm_clkdiv u_clkdiv (
        .i_clock   (i_clock),
        .i_rst_n   (rst_n),
        .i_run     (div_run),
        .i_divisor (top_reg.div),
        .o_tick    (tad_tick),
        .o_tad_clk (tad_clk)
    );

    // format follows the current control bits, not those at conversion
    acrfcm_format u_format (
        .i_raw   (top_reg.buffer),
        .i_res12 (top_reg.res12),
        .i_output_format_select  (top_reg.output_format_select),
        .o_word  (fmt_word)
    );

    // absent channels never hold a set enable
    assign en_all = {top_reg.en_hi, top_reg.en_lo};
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        assign en_seen[ch] = en_all[ch] & CHAN_IMPL[ch];
    end

    // clip the differential input to the span of the chosen resolution
    always_comb begin
        logic signed [IN_W-1:0] v;
        v = i_diff_input;
        if (top_reg.res12) begin
            if (v > CODE12_MAX) begin
                v = CODE12_MAX;
            end else if (v < CODE12_MIN) begin
                v = CODE12_MIN;
            end
        end else begin
            v = v >>> RES10_SHIFT;
            if (v > CODE10_MAX) begin
                v = CODE10_MAX;
            end else if (v < CODE10_MIN) begin
                v = CODE10_MIN;
            end
        end
        quant = v[RAW_W-1:0];
    end

    // register port, conversion sequence and read path
    always_comb begin
        logic start;
        logic [CHAN_W-1:0] ch_idx;
        start = 1'b0;
        ch_idx = '0;
        top_next = top_reg;
        top_next.rdata = '0;

        // writes; a start only counts while on and idle
        if (i_wr) begin
            unique case (i_addr)
                REG_CTRL1: begin
                    top_next.on = i_wdata[CTRL_ON_BIT];
                    top_next.res12 = i_wdata[CTRL_RES_BIT];
                    top_next.output_format_select = i_wdata[CTRL_OUTPUT_FORMAT_SELECT_LSB +: 2];
                    if (!i_wdata[CTRL_DONE_BIT]) begin
                        top_next.done = 1'b0;
                    end
                    start = i_wdata[CTRL_START_BIT] & i_wdata[CTRL_ON_BIT]
                            & (top_reg.st == ST_IDLE);
                end
                REG_CLKDIV: begin
                    top_next.div = i_wdata[DIV_W-1:0];
                end
                REG_CHSEL: begin
                    top_next.chsel = i_wdata[CHAN_W-1:0];
                end
                REG_ENLO: begin
                    top_next.en_lo = i_wdata[ENLO_W-1:0]
                                   & CHAN_IMPL[ENLO_W-1:0];
                end
                REG_ENHI: begin
                    // upper bits are not stored at all
                    top_next.en_hi = i_wdata[ENHI_W-1:0]
                                   & CHAN_IMPL[NUM_CHAN-1:ENLO_W];
                end
                default: begin
                end
            endcase
        end

        // read data stand in the cycle after the strobe only
        if (i_rd) begin
            unique case (i_addr)
                REG_CTRL1: begin
                    top_next.rdata[CTRL_ON_BIT] = top_reg.on;
                    top_next.rdata[CTRL_RES_BIT] = top_reg.res12;
                    top_next.rdata[CTRL_OUTPUT_FORMAT_SELECT_LSB +: 2] = top_reg.output_format_select;
                    top_next.rdata[CTRL_BUSY_BIT] = (top_reg.st != ST_IDLE);
                    top_next.rdata[CTRL_DONE_BIT] = top_reg.done;
                end
                REG_CLKDIV: begin
                    top_next.rdata[DIV_W-1:0] = top_reg.div;
                end
                REG_CHSEL: begin
                    top_next.rdata[CHAN_W-1:0] = top_reg.chsel;
                end
                REG_ENLO: begin
                    top_next.rdata[ENLO_W-1:0] = en_seen[ENLO_W-1:0];
                end
                REG_ENHI: begin
                    // bits 15-2 stay zero
                    top_next.rdata[ENHI_W-1:0] = en_seen[NUM_CHAN-1:ENLO_W];
                end
                REG_RESULT: begin
                    top_next.rdata = fmt_word;
                end
                default: begin
                end
            endcase
        end

        // sample for a fixed span, then convert; channel latched at start
        unique case (top_reg.st)
            ST_IDLE: begin
                top_next.connect = 1'b0;
                if (start) begin
                    top_next.st = ST_SAMPLE;
                    top_next.phase = '0;
                    top_next.conv_ch = top_reg.chsel;
                    top_next.done = 1'b0;
                end
            end
            ST_SAMPLE: begin
                if (tad_tick) begin
                    if (top_reg.phase == CNT_W'(SAMP_LEN - 1)) begin
                        top_next.st = ST_CONVERT;
                        top_next.phase = '0;
                        ch_idx = top_reg.conv_ch;
                        // unit joins only for an enabled channel
                        if (ch_idx < CHAN_W'(NUM_CHAN)) begin
                            top_next.connect = en_seen[ch_idx];
                        end
                    end else begin
                        top_next.phase = top_reg.phase + 1'b1;
                    end
                end
            end
            ST_CONVERT: begin
                if (tad_tick) begin
                    if (top_reg.phase == CNT_W'(CONV_LEN - 1)) begin
                        top_next.st = ST_IDLE;
                        top_next.connect = 1'b0;
                        top_next.buffer = quant;
                        top_next.done = 1'b1;
                    end else begin
                        top_next.phase = top_reg.phase + 1'b1;
                    end
                end
            end
        endcase

        // turning the converter off abandons any sequence
        if (!top_next.on) begin
            top_next.st = ST_IDLE;
            top_next.connect = 1'b0;
        end

        // phase flags registered so the pins come straight from flops
        top_next.sampling = (top_next.st == ST_SAMPLE);
        top_next.converting = (top_next.st == ST_CONVERT);
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            top_reg <= '0;
            top_reg.st <= ST_IDLE;
        end else begin
            top_reg <= top_next;
        end
    end

    // conversion clock output registered once more for a clean pin
    logic conv_clk_reg;
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            conv_clk_reg <= 1'b0;
        end else begin
            conv_clk_reg <= tad_clk;
        end
    end

    assign o_rdata = top_reg.rdata;
    assign o_conv_clock = conv_clk_reg;
    assign o_sampling = top_reg.sampling;
    assign o_converting = top_reg.converting;
    assign o_charge_unit_connect = top_reg.connect;
    assign o_charge_unit_channel = top_reg.conv_ch;
    assign o_done = top_reg.done;
endmodule

// ===== testbench/acrfcm_front_model.sv
// Purpose: analog front end stand-in feeding the differential count
// Assumes: the bench commands the level of each conversion
// Notes:   outside a conversion the line wanders so a stray sample shows
`timescale 1ns/100ps
module acrfcm_front_model
    import acrfcm_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_sampling,
    input  wire logic                   i_converting,
    input  wire logic signed [IN_W-1:0] i_level,
    output logic signed [IN_W-1:0]      o_diff
);
    logic hold_reg = 1'b0;
    logic tog_reg  = 1'b0;

    // one extra cycle of hold covers the final sampling edge
    always_ff @(posedge i_clock) begin
        hold_reg <= i_converting;
        tog_reg  <= ~tog_reg;
    end

    // settled from sampling to one cycle past the end of conversion only
    assign o_diff = (i_sampling | i_converting | hold_reg) ? i_level
                  : i_level ^ {IN_W{tog_reg}} ^ 16'sh5A5A;
endmodule

// ===== testbench/acrfcm_top_properties.sv
// Purpose: port-level properties of the converter control block
// Assumes: format, resolution and divisor are snooped from bus writes
// Notes:   aborts by clearing the on bit are not modelled here
`timescale 1ns/100ps
module acrfcm_checker
    import acrfcm_pkg::*;
#(
    parameter logic [NUM_CHAN-1:0] CHAN_IMPL = 18'h3FFFF,
    parameter int                  CONV_LEN  = CONV_TADS,
    parameter int                  SAMP_LEN  = SAMPLE_TADS
)
(
    input wire logic                   i_clock,
    input wire logic                   i_rst_n,
    input wire logic [ADDR_W-1:0]      i_addr,
    input wire logic [DATA_W-1:0]      i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic signed [IN_W-1:0] i_diff_input,
    input wire logic [DATA_W-1:0]      o_rdata,
    input wire logic                   o_conv_clock,
    input wire logic                   o_sampling,
    input wire logic                   o_converting,
    input wire logic                   o_charge_unit_connect,
    input wire logic [CHAN_W-1:0]      o_charge_unit_channel,
    input wire logic                   o_done
);
    logic [1:0]       output_format_select_reg;
    logic             res_reg;
    logic             rres_reg;
    logic [DIV_W-1:0] div_reg;
    logic [15:0]      scnt_reg;
    logic [15:0]      ccnt_reg;

    // shadow of the control fields; counters give phase lengths
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            output_format_select_reg <= 2'h0;
            res_reg  <= 1'b0;
            rres_reg <= 1'b0;
            div_reg  <= '0;
            scnt_reg <= 16'h0;
            ccnt_reg <= 16'h0;
        end else begin
            if (i_wr && i_addr == REG_CTRL1) begin
                output_format_select_reg <= i_wdata[CTRL_OUTPUT_FORMAT_SELECT_LSB+:2];
                res_reg  <= i_wdata[CTRL_RES_BIT];
            end
            if (i_wr && i_addr == REG_CLKDIV) begin
                div_reg <= i_wdata[DIV_W-1:0];
            end
            rres_reg <= i_rd && i_addr == REG_RESULT;
            scnt_reg <= o_sampling ? scnt_reg + 16'h1 : 16'h0;
            ccnt_reg <= o_converting ? ccnt_reg + 16'h1 : 16'h0;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
        else $error("read data not zero outside a read answer");
    a_enhi_upper: assert property (
        $past(i_rd) && $past(i_addr) == REG_ENHI |-> o_rdata[15:2] == 14'h0)
        else $error("upper enable bits not zero");
    a_int12_clip: assert property (
        rres_reg && res_reg && output_format_select_reg == OUTPUT_FORMAT_SELECT_INT |-> o_rdata[15:12] == 4'h0)
        else $error("12-bit integer has upper bits set");
    a_int10_width: assert property (
        rres_reg && !res_reg && output_format_select_reg == OUTPUT_FORMAT_SELECT_INT |-> o_rdata[15:10] == 6'h0)
        else $error("10-bit integer wider than 10 bits");
    a_sint_extend: assert property (
        rres_reg && res_reg && output_format_select_reg == OUTPUT_FORMAT_SELECT_SINT
        |-> o_rdata[15:13] == {3{o_rdata[12]}})
        else $error("signed integer not sign extended");
    a_frac_pad: assert property (
        rres_reg && res_reg && output_format_select_reg == OUTPUT_FORMAT_SELECT_FRAC |-> o_rdata[3:0] == 4'h0)
        else $error("fraction low bits not zero");
    a_sfrac10_pad: assert property (
        rres_reg && !res_reg && output_format_select_reg == OUTPUT_FORMAT_SELECT_SFRAC |-> o_rdata[4:0] == 5'h0)
        else $error("10-bit signed fraction low bits not zero");
    a_connect_conv: assert property (
        o_charge_unit_connect |-> o_converting
        && CHAN_IMPL[o_charge_unit_channel])
        else $error("charge unit joined outside conversion");
    a_samp_len: assert property (
        $fell(o_sampling) |-> scnt_reg == SAMP_LEN * (div_reg + 1))
        else $error("sample phase length wrong");
    a_conv_len: assert property (
        $fell(o_converting) |-> ccnt_reg == CONV_LEN * (div_reg + 1) && o_done)
        else $error("convert phase length wrong or no done");
    a_chan_hold: assert property (
        o_converting && $past(o_converting) |-> $stable(o_charge_unit_channel))
        else $error("channel moved during conversion");

    c_done: cover property ($rose(o_done));
    c_connect: cover property ($rose(o_charge_unit_connect));
    c_sfrac: cover property (rres_reg && output_format_select_reg == OUTPUT_FORMAT_SELECT_SFRAC);
endmodule

bind acrfcm_top acrfcm_checker #(
    .CHAN_IMPL(CHAN_IMPL),
    .CONV_LEN (CONV_LEN),
    .SAMP_LEN (SAMP_LEN)
) u_acrfcm_checker (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_diff_input(i_diff_input), .o_rdata(o_rdata),
    .o_conv_clock(o_conv_clock), .o_sampling(o_sampling),
    .o_converting(o_converting),
    .o_charge_unit_connect(o_charge_unit_connect),
    .o_charge_unit_channel(o_charge_unit_channel), .o_done(o_done)
);

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: one system clock, registers on a plain strobe port
// Notes:   read answers are checked from a queue by a monitor process
`timescale 1ns/100ps
module tb_top
    import acrfcm_pkg::*;
;
    localparam logic [NUM_CHAN-1:0] IMPL = 18'h2FFFE;
    localparam logic [NUM_CHAN-1:0] EN   = 18'h3A5A5;

    logic                   clock;
    logic                   rst_n;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      wdata;
    logic                   wr_s;
    logic                   rd_s;
    logic signed [IN_W-1:0] level;
    logic signed [IN_W-1:0] diff;
    logic [DATA_W-1:0]      rdata;
    logic                   sampling;
    logic                   converting;
    logic                   connect;
    logic [CHAN_W-1:0]      chan;
    logic                   done;
    logic                   cclk;
    logic                   rd_d = 1'b0;
    logic [DATA_W-1:0]      exp_q[$];
    int                     fail_count = 0;
    int                     cmp_count = 0;
    int                     cycles = 0;
    int                     vals[8] = '{5000, 4095, 1, 0, -1, -4096, -5000, 1234};

    acrfcm_top #(.CHAN_IMPL(IMPL)) u_acrfcm_top (
        .i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .i_diff_input(diff), .o_rdata(rdata),
        .o_conv_clock(cclk), .o_sampling(sampling), .o_converting(converting),
        .o_charge_unit_connect(connect), .o_charge_unit_channel(chan),
        .o_done(done)
    );

    acrfcm_front_model u_acrfcm_front_model (
        .i_clock(clock), .i_sampling(sampling), .i_converting(converting),
        .i_level(level), .o_diff(diff)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
        cmp_count++;
        if (got !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, e);
        end
    endtask

    // hang guard: whole run needs well under two thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("BAD %0t run did not finish", $time);
            end_sim();
        end
    end

    // monitor: read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= rd_s;
        if (rd_d) begin
            chk(rdata, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clock);
        wr_s  <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        rd_s <= 1'b0;
    endtask

    function automatic logic [DATA_W-1:0] ctl(logic r, logic [1:0] f, logic s);
        return {1'b1, 4'h0, r, f, 6'h0, s, 1'b0};
    endfunction

    // expected bus word: clamp to the span, then justify per format
    function automatic logic [DATA_W-1:0] fmt(int v, logic r, int f);
        int c;
        c = r ? v : (v >>> 2);
        if (c > (r ? 4095 : 1023)) c = r ? 4095 : 1023;
        if (c < (r ? -4096 : -1024)) c = r ? -4096 : -1024;
        case (f)
            0: return (c < 0) ? 16'h0 : 16'(c);
            1: return 16'(c);
            2: return (c < 0) ? 16'h0 : 16'(c << (r ? 4 : 6));
            default: return 16'(c << (r ? 3 : 5));
        endcase
    endfunction

    task automatic conv(input int v, input logic r, input int ch, input int dv);
        int n;
        logic seen;
        level <= 16'(v);
        wr(REG_CLKDIV, 16'(dv));
        wr(REG_CHSEL, 16'(ch));
        wr(REG_CTRL1, ctl(r, 2'h0, 1'b1));
        n = 0;
        while (sampling !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (sampling === 1'b1) begin
            @(negedge clock);
            n++;
        end
        chk(16'(n), 16'(dv + 1));
        chk({15'h0, connect}, {15'h0, EN[ch] & IMPL[ch]});
        chk(16'(chan), 16'(ch));
        n = 0;
        seen = 1'b0;
        while (converting === 1'b1) begin
            seen = seen | cclk;
            @(negedge clock);
            n++;
        end
        chk(16'(n), 16'(CONV_TADS * (dv + 1)));
        chk({15'h0, seen}, 16'h1);
        chk({15'h0, done}, 16'h1);
        for (int f = 0; f < 4; f++) begin
            wr(REG_CTRL1, ctl(r, 2'(f), 1'b0));
            rd(REG_RESULT, fmt(v, r, f));
        end
        rd(REG_CTRL1, ctl(r, 2'h3, 1'b0));
        chk({15'h0, cclk}, 16'h0);
    endtask

    initial begin
        addr  = '0;
        wdata = '0;
        wr_s  = 1'b0;
        rd_s  = 1'b0;
        level = '0;
        rst_n = 1'b0;
        void'($urandom(14));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(REG_ENLO, 16'h0);
        rd(REG_ENHI, 16'h0);
        wr(REG_ENLO, 16'hA5A5);
        wr(REG_ENHI, 16'hFFFF);
        wr(4'hF, 16'h1234);
        rd(REG_ENLO, EN[15:0] & IMPL[15:0]);
        rd(REG_ENHI, {14'h0, EN[17:16] & IMPL[17:16]});
        rd(4'hF, 16'h0);
        wr(REG_CLKDIV, 16'hA5C3);
        rd(REG_CLKDIV, 16'h00C3);
        wr(REG_CHSEL, 16'hFFF3);
        rd(REG_CHSEL, 16'h0013);
        // format reads leave idle time before each new start
        for (int i = 0; i < 16; i++) begin
            conv(vals[i % 8], i < 8, (i * 7 + 9) % 18, i % 3);
        end
        for (int i = 0; i < 4; i++) begin
            conv(int'($urandom_range(12000)) - 6000, 1'($urandom()),
                 int'($urandom_range(17)), int'($urandom_range(3)));
        end
        end_sim();
    end
endmodule
